// ==== hw/ssp_master_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// External synchronous master: makes the shift clock, moves words.
// ============================================================
module ssp_master_end import ssp_pkg::*; #(
	parameter int unsigned HALF_CYC = LINK_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ssp_link_if.mst link
);
	// ============================================================
	// Declarations
	// ============================================================
	ssp_link_state_e state_q; // Clock generator state.
	logic [7:0] div_q; // Half-period countdown.
	logic [3:0] idx_q, len_q; // Bit index and word length.
	logic [8:0] word_q; // Word to send.
	logic [8:0] rxw_q; // Word received from the slave.
	logic send_q; // High when the master drives the data wire.
	logic ck_q, dt_q; // Clock and data outputs.
	logic done_q; // Sticky transfer-finished flag.
	logic done_seen_q; // Done flag as the setup cycle captured it.
	logic dt_s; // Synchronised data wire.
	logic wr, rd, setup, mapped, start, finish, stat_rd;
	logic [31:0] rdata_d; // Read data for the addressed register.

	localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);

	// ============================================================
	// Bus decode
	// ============================================================
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign mapped = (paddr == OFS_M_CMD) || (paddr == OFS_M_STAT) ||
		(paddr == OFS_M_RXD);
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	// Commands while busy are ignored.
	assign start = wr & (paddr == OFS_M_CMD) & (state_q == SSP_IDLE);
	assign stat_rd = rd & (paddr == OFS_M_STAT);
	assign finish = (state_q == SSP_HIGH) && (div_q == 8'h00) &&
		(idx_q == len_q - 4'h1);

	ssp_sync2 #(.WIDTH(1)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(link.dt),
		.q(dt_s)
	);

	// ============================================================
	// Clock generator and shifter
	// ============================================================
	// Low half, then high half per bit; data changes at the rise and
	// is sampled by the receiving side at the fall.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SSP_IDLE;
			div_q <= 8'h00;
			idx_q <= 4'h0;
			len_q <= WORD_SHORT;
			word_q <= 9'h000;
			rxw_q <= 9'h000;
			send_q <= 1'b0;
			ck_q <= 1'b0;
			dt_q <= 1'b1;
		end else begin
			unique case (state_q)
				SSP_IDLE: begin
					if (start) begin
						word_q <= pwdata[8:0];
						len_q <= pwdata[CMD_NINE] ? WORD_LONG : WORD_SHORT;
						send_q <= pwdata[CMD_SEND];
						rxw_q <= 9'h000;
						idx_q <= 4'h0;
						dt_q <= pwdata[0];
						div_q <= HALF_LOAD;
						state_q <= SSP_LOW;
					end
				end
				SSP_LOW: begin
					if (div_q == 8'h00) begin
						ck_q <= 1'b1;
						dt_q <= word_q[idx_q];
						div_q <= HALF_LOAD;
						state_q <= SSP_HIGH;
					end else begin
						div_q <= div_q - 8'h01;
					end
				end
				SSP_HIGH: begin
					if (div_q == 8'h00) begin
						ck_q <= 1'b0;
						if (!send_q) begin
							rxw_q[idx_q] <= dt_s;
						end
						if (finish) begin
							state_q <= SSP_IDLE;
						end else begin
							idx_q <= idx_q + 4'h1;
							div_q <= HALF_LOAD;
							state_q <= SSP_LOW;
						end
					end else begin
						div_q <= div_q - 8'h01;
					end
				end
				default: state_q <= SSP_IDLE;
			endcase
		end
	end

	// Done flag: set at the end of a transfer, cleared by a status read;
	// the set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (stat_rd && done_seen_q) begin
			// Only a read that reported the flag clears it, so a finish
			// landing on the setup edge is not lost.
			done_q <= 1'b0;
		end
	end

	assign link.ck = ck_q;
	assign link.mst_dt_o = dt_q;
	assign link.mst_dt_oe_n = ~((state_q != SSP_IDLE) & send_q);

	// ============================================================
	// Read data
	// ============================================================
	// Selects the addressed register image.
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			OFS_M_STAT: begin
				rdata_d[ST_BUSY] = (state_q != SSP_IDLE);
				rdata_d[ST_DONE] = done_q;
			end
			OFS_M_RXD: rdata_d[8:0] = rxw_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Captures read data in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			done_seen_q <= 1'b0;
		end else if (setup) begin
			prdata <= rdata_d;
			done_seen_q <= done_q;
		end
	end
endmodule
`default_nettype wire

// ==== hw/ssp_slave_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Synchronous slave serial port with APB register access.
// ============================================================
// Behaviour
// - Slave mode when clock source select cleared.
// - Master supplies shift clock; slave never drives it.
// - Shifting continues during low-power modes.
// - Held word moves to shift register at once.
// - Transmit-ready stays clear while a word waits.
// - After shift-out, waiting word loads, flag sets.
// - Transmit-ready with enable wakes chip, interrupts.
// - Ninth transmit bit sent when nine-bit selected.
// - Holding write with transmit enable starts transfer.
// - Software configures modes, clears receive enables first.
// - Single receive enable ignored in slave mode.
// - Continuous receive keeps receiving in low power.
// - Completed word moves into receive holding register.
// - Receive-ready with enable wakes chip, interrupts.
// - Completed reception sets receive-ready, requests interrupt.
// - Ninth bit and errors shown in receive status.
// - Holding read returns oldest received word.
// - Clearing continuous receive clears receive errors.
// - Software sets global and peripheral interrupt enables.
// - Software starts reception by setting continuous enable.
// - Receive data sampled at shift clock falling edge.
module ssp_slave_end import ssp_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sleep_mode,
	output logic int_req,
	output logic wake_req,
	ssp_link_if.dev link
);
	// ============================================================
	// Declarations
	// ============================================================
	logic ck_s, dt_s; // Synchronised link clock and data.
	logic ck_prev_q; // Previous synchronised clock, for edge finding.
	logic dt_prev_q; // Synchronised data one cycle earlier.
	logic fall; // One-cycle pulse at a falling shift clock edge.
	logic port_en_q, rx_nine_q, single_q, cont_q; // Receive control.
	logic overrun_error_flag_q, rx_ninth_q; // Overrun flag and received ninth bit.
	logic clk_src_q, tx_nine_q, tx_en_q, sync_q, tx_ninth_q; // Tx ctrl.
	logic txie_q, rcie_q, gie_q, peripheral_interrupt_enable_q; // Interrupt enables.
	logic hold_full_q; // Transmit holding register occupied.
	logic [7:0] hold_q; // Transmit holding register.
	logic [8:0] tsr_q; // Transmit shift register.
	logic tsr_busy_q; // A word is loaded in the shift register.
	logic [3:0] tx_cnt_q, tx_len_q; // Transmit bit index and length.
	logic [8:0] rsr_q; // Receive shift register.
	logic [3:0] rx_cnt_q; // Receive bit index.
	logic [8:0] word_d; // Word as it stands with the current bit.
	logic [7:0] rc_hold_q; // Receive holding register.
	logic rc_full_q; // Receive holding register holds an unread word.
	logic rd_full_q; // Holding was full when the read was set up.
	logic slave_on, tx_on, rx_on; // Mode qualifiers.
	logic setup, wr, rd, mapped; // Bus phase decode.
	logic tsr_load, hold_write, rc_pop, rx_done, accept; // Events.
	logic txif, rcif; // Transmit-ready and receive-ready flags.
	logic [31:0] rdata_d; // Read data for the addressed register.
	logic [3:0] rx_len; // Current receive word length.

	// ============================================================
	// Link input synchronisation and edge detection
	// ============================================================
	// The clock pin is only sampled here; it is never driven.
	ssp_sync2 #(.WIDTH(2)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({link.ck, link.dt}),
		.q({ck_s, dt_s})
	);

	// Remembers the synchronised clock to find its falling edge, and the
	// data as it stood while the clock was still high. The master may let
	// go of the wire at its last falling edge, so the bit is taken from
	// the cycle before the edge shows up here.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_prev_q <= 1'b0;
			dt_prev_q <= 1'b1;
		end else begin
			ck_prev_q <= ck_s;
			dt_prev_q <= dt_s;
		end
	end

	// Link clock drives shifting; no low-power input gates it.
	assign fall = ck_prev_q & ~ck_s;

	// ============================================================
	// Mode qualifiers and bus decode
	// ============================================================
	assign slave_on = port_en_q & sync_q & ~clk_src_q;
	assign tx_on = slave_on & tx_en_q;
	// Only the continuous enable steers reception.
	assign rx_on = slave_on & cont_q;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign mapped = (paddr == OFS_RCV_CTRL) || (paddr == OFS_TX_HOLD) ||
		(paddr == OFS_TX_CTRL) || (paddr == OFS_RX_HOLD) ||
		(paddr == OFS_INT_EN) || (paddr == OFS_INT_FLAG) ||
		(paddr == OFS_INT_CTRL);
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;

	// ============================================================
	// Control registers
	// ============================================================
	// Stores the software-written control and enable fields.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_en_q <= 1'b0;
			rx_nine_q <= 1'b0;
			single_q <= 1'b0;
			cont_q <= 1'b0;
			clk_src_q <= 1'b0;
			tx_nine_q <= 1'b0;
			tx_en_q <= 1'b0;
			sync_q <= 1'b0;
			tx_ninth_q <= 1'b0;
			txie_q <= 1'b0;
			rcie_q <= 1'b0;
			gie_q <= 1'b0;
			peripheral_interrupt_enable_q <= 1'b0;
		end else if (wr) begin
			unique case (paddr)
				OFS_RCV_CTRL: begin
					port_en_q <= pwdata[RC_PORT_EN];
					rx_nine_q <= pwdata[RC_NINE];
					single_q <= pwdata[RC_SINGLE]; // Stored and read back, steers nothing.
					cont_q <= pwdata[RC_CONT];
				end
				OFS_TX_CTRL: begin
					clk_src_q <= pwdata[TX_CLK_SRC];
					tx_nine_q <= pwdata[TX_NINE];
					tx_en_q <= pwdata[TX_EN];
					sync_q <= pwdata[TX_SYNC];
					tx_ninth_q <= pwdata[TX_NINTH];
				end
				OFS_INT_EN: begin
					txie_q <= pwdata[IE_TX];
					rcie_q <= pwdata[IE_RX];
				end
				OFS_INT_CTRL: begin
					gie_q <= pwdata[IC_GLOBAL];
					peripheral_interrupt_enable_q <= pwdata[IC_PERIPH];
				end
				default: begin
					// Other offsets hold no writable control.
				end
			endcase
		end
	end

	// ============================================================
	// Transmit path
	// ============================================================
	assign hold_write = wr & (paddr == OFS_TX_HOLD);
	// An idle shift register takes the held word at once.
	assign tsr_load = tx_on & hold_full_q & ~tsr_busy_q;

	// Holding register: a write fills it, a load into the shift register
	// empties it; a write in the same cycle as a load keeps it full.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_full_q <= 1'b0;
			hold_q <= 8'h00;
		end else if (hold_write) begin
			hold_full_q <= 1'b1;
			hold_q <= pwdata[7:0];
		end else if (tsr_load) begin
			hold_full_q <= 1'b0;
		end
	end

	// Shift register: loads, then moves one bit per falling edge,
	// so each bit stands a whole clock period for the master.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tsr_q <= 9'h000;
			tsr_busy_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_len_q <= WORD_SHORT;
		end else if (!tx_on) begin
			tsr_busy_q <= 1'b0;
		end else if (tsr_load) begin
			tsr_q <= {tx_nine_q & tx_ninth_q, hold_q};
			tsr_busy_q <= 1'b1;
			tx_cnt_q <= 4'h0;
			tx_len_q <= tx_nine_q ? WORD_LONG : WORD_SHORT;
		end else if (tsr_busy_q && fall) begin
			if (tx_cnt_q == tx_len_q - 4'h1) begin
				tsr_busy_q <= 1'b0;
			end else begin
				tsr_q <= tsr_q >> 1;
				tx_cnt_q <= tx_cnt_q + 4'h1;
			end
		end
	end

	// The pin is driven only while a word shifts and reception is off.
	assign link.dev_dt_o = tsr_q[0];
	assign link.dev_dt_oe_n = ~(tsr_busy_q & ~cont_q);
	// Ready only once the holding register is empty.
	assign txif = ~hold_full_q;

	// ============================================================
	// Receive path
	// ============================================================
	assign rx_len = rx_nine_q ? WORD_LONG : WORD_SHORT;
	assign rx_done = rx_on & fall & (rx_cnt_q == rx_len - 4'h1);
	assign rc_pop = rd & (paddr == OFS_RX_HOLD) & rd_full_q;
	// A word lands unless an overrun stands; a read in the same cycle
	// makes room for it.
	assign accept = rx_done & ~overrun_error_flag_q & (~rc_full_q | rc_pop);

	// Builds the finished word including the bit being sampled.
	always_comb begin
		word_d = rsr_q;
		word_d[rx_cnt_q] = dt_prev_q;
		if (!rx_nine_q) begin
			word_d[8] = 1'b0;
		end
	end

	// Samples one data bit at each falling shift clock edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsr_q <= 9'h000;
			rx_cnt_q <= 4'h0;
		end else if (!rx_on) begin
			rx_cnt_q <= 4'h0;
		end else if (fall) begin
			rsr_q[rx_cnt_q] <= dt_prev_q;
			rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
		end
	end

	// Receive holding register and its ninth bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_hold_q <= 8'h00;
			rx_ninth_q <= 1'b0;
			rc_full_q <= 1'b0;
		end else if (accept) begin
			rc_hold_q <= word_d[7:0];
			rx_ninth_q <= word_d[8];
			rc_full_q <= 1'b1;
		end else if (rc_pop) begin
			rc_full_q <= 1'b0;
		end
	end

	// Overrun keeps the earlier word; clearing reception clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overrun_error_flag_q <= 1'b0;
		end else if (!rx_on) begin
			overrun_error_flag_q <= 1'b0;
		end else if (rx_done && rc_full_q && !rc_pop) begin
			overrun_error_flag_q <= 1'b1;
		end
	end

	assign rcif = rc_full_q;

	// ============================================================
	// Interrupt and wake requests
	// ============================================================
	// Wake works without the global enables; the core branch needs them.
	assign wake_req = sleep_mode &
		((txif & txie_q) | (rcif & rcie_q));
	assign int_req = gie_q & peripheral_interrupt_enable_q &
		((txif & txie_q) | (rcif & rcie_q));

	// ============================================================
	// Read data
	// ============================================================
	// Selects the addressed register image; unmapped reads give zero.
	always_comb begin
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			OFS_RCV_CTRL: begin
				rdata_d[RC_PORT_EN] = port_en_q;
				rdata_d[RC_NINE] = rx_nine_q;
				rdata_d[RC_SINGLE] = single_q;
				rdata_d[RC_CONT] = cont_q;
				rdata_d[RC_FRAME_ERR] = 1'b0; // No framing in this mode.
				rdata_d[RC_OVERRUN] = overrun_error_flag_q;
				rdata_d[RC_NINTH] = rx_ninth_q;
			end
			OFS_TX_CTRL: begin
				rdata_d[TX_CLK_SRC] = clk_src_q;
				rdata_d[TX_NINE] = tx_nine_q;
				rdata_d[TX_EN] = tx_en_q;
				rdata_d[TX_SYNC] = sync_q;
				rdata_d[TX_EMPTY] = ~tsr_busy_q;
				rdata_d[TX_NINTH] = tx_ninth_q;
			end
			OFS_RX_HOLD: rdata_d[7:0] = rc_hold_q;
			OFS_INT_EN: begin
				rdata_d[IE_TX] = txie_q;
				rdata_d[IE_RX] = rcie_q;
			end
			OFS_INT_FLAG: begin
				rdata_d[IE_TX] = txif;
				rdata_d[IE_RX] = rcif;
			end
			OFS_INT_CTRL: begin
				rdata_d[IC_GLOBAL] = gie_q;
				rdata_d[IC_PERIPH] = peripheral_interrupt_enable_q;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Captures read data and holding state in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			rd_full_q <= 1'b0;
		end else if (setup) begin
			prdata <= rdata_d;
			rd_full_q <= rc_full_q;
		end
	end
endmodule
`default_nettype wire

// ==== hw/ssp_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Two-flop synchroniser for inputs from outside the clock domain.
// ============================================================
module ssp_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q; // First stage, read only by the second.

	// Passes the input through two flip-flops.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== pkg/ssp_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Link between the slave port and the external master.
// ============================================================
interface ssp_link_if;
	logic ck; // Shift clock, made by the master only.
	logic dev_dt_o; // Data driven by the slave port.
	logic dev_dt_oe_n; // Low while the slave port drives data.
	logic mst_dt_o; // Data driven by the master.
	logic mst_dt_oe_n; // Low while the master drives data.
	logic dt; // Resolved data wire, pulled high when nobody drives.

	// Resolves the shared data wire from both enables.
	assign dt = !dev_dt_oe_n ? dev_dt_o :
		(!mst_dt_oe_n ? mst_dt_o : 1'b1);

	modport dev (input ck, input dt, output dev_dt_o, output dev_dt_oe_n);
	modport mst (output ck, input dt, output mst_dt_o, output mst_dt_oe_n);
endinterface
`default_nettype wire

// ==== pkg/ssp_pkg.sv ====
`default_nettype none
// ============================================================
// Shared constants for the synchronous slave port and its master.
// ============================================================
package ssp_pkg;

	// Register offsets of the slave port (byte addresses, one word each).
	localparam logic [7:0] OFS_RCV_CTRL = 8'h00;
	localparam logic [7:0] OFS_TX_HOLD = 8'h04;
	localparam logic [7:0] OFS_TX_CTRL = 8'h08;
	localparam logic [7:0] OFS_RX_HOLD = 8'h0C;
	localparam logic [7:0] OFS_INT_EN = 8'h10;
	localparam logic [7:0] OFS_INT_FLAG = 8'h14;
	localparam logic [7:0] OFS_INT_CTRL = 8'h18;

	// Register offsets of the master's command block.
	localparam logic [7:0] OFS_M_CMD = 8'h00;
	localparam logic [7:0] OFS_M_STAT = 8'h04;
	localparam logic [7:0] OFS_M_RXD = 8'h08;

	// Field positions of the receive status/control register.
	localparam int unsigned RC_PORT_EN = 7;
	localparam int unsigned RC_NINE = 6;
	localparam int unsigned RC_SINGLE = 5;
	localparam int unsigned RC_CONT = 4;
	localparam int unsigned RC_FRAME_ERR = 2;
	localparam int unsigned RC_OVERRUN = 1;
	localparam int unsigned RC_NINTH = 0;

	// Field positions of the transmit status/control register.
	localparam int unsigned TX_CLK_SRC = 7;
	localparam int unsigned TX_NINE = 6;
	localparam int unsigned TX_EN = 5;
	localparam int unsigned TX_SYNC = 4;
	localparam int unsigned TX_EMPTY = 1;
	localparam int unsigned TX_NINTH = 0;

	// Field positions of the enable, flag and interrupt control registers.
	localparam int unsigned IE_RX = 1;
	localparam int unsigned IE_TX = 0;
	localparam int unsigned IC_GLOBAL = 7;
	localparam int unsigned IC_PERIPH = 6;

	// Field positions of the master's command and status registers.
	localparam int unsigned CMD_NINE = 9;
	localparam int unsigned CMD_SEND = 10;
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_DONE = 1;

	// Word lengths in bits.
	localparam logic [3:0] WORD_SHORT = 4'h8;
	localparam logic [3:0] WORD_LONG = 4'h9;

	// Timing: system clock and link clock periods in nanoseconds.
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned LINK_PERIOD_NS = 200;
	localparam int unsigned LINK_HALF_CYC =
		(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
		(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));

	// States of the master's clock generator.
	typedef enum logic [1:0] {
		SSP_IDLE = 2'b00,
		SSP_LOW = 2'b01,
		SSP_HIGH = 2'b11
	} ssp_link_state_e;

endpackage
`default_nettype wire

// ==== testbench/ssp_link_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checks on the link wires between the slave port and master.
// ============================================================
module ssp_link_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ck,
	input wire logic dev_dt_o,
	input wire logic dev_dt_oe_n,
	input wire logic mst_dt_o,
	input wire logic mst_dt_oe_n,
	input wire logic dt
);
	// All checks share the system clock and its reset.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Each half of the shift clock lasts four system clocks, the master's
	// default half period for a 200 ns link clock.
	a_one_driver: assert property (dev_dt_oe_n || mst_dt_oe_n)
		else $error("both ends drive the data wire");
	a_ck_high_len: assert property (
		$rose(ck) |-> ck[*4] ##1 !ck)
		else $error("shift clock high time wrong");
	a_ck_low_len: assert property (
		$fell(ck) |-> (!ck)[*4])
		else $error("shift clock low time too short");
	a_mst_start: assert property (
		$fell(mst_dt_oe_n) |-> (!ck)[*4] ##1 ck)
		else $error("master frame start wrong");
	a_mst_bit_hold: assert property (
		$fell(ck) && !mst_dt_oe_n |-> $stable(dt))
		else $error("data moved at sampling edge");
	a_dev_bit_hold: assert property (
		$fell(ck) && !dev_dt_oe_n && $past(!dev_dt_oe_n) |->
		$stable(dev_dt_o))
		else $error("slave data moved at sampling edge");
	a_dev_load_first: assert property (
		$fell(dev_dt_oe_n) |-> !ck)
		else $error("slave began driving with clock high");
	a_dev_release: assert property (
		$rose(dev_dt_oe_n) |-> !ck)
		else $error("slave released data inside a bit");
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	num_errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); \
	end end
// ============================================================
// Both ends joined on one link, driven over their APB ports.
// ============================================================
module tb_top;
	import ssp_pkg::*;
	logic pclk = 1'b0; // System clock.
	logic presetn = 1'b0; // Reset, low at start.
	logic psel = 1'b0; // Select of the slave port.
	logic psel_m = 1'b0; // Select of the master.
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sleep_mode = 1'b0; // Chip in low-power mode.
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, prdata_m, r;
	logic pready, pready_m, pslverr, pslverr_m, int_req, wake_req, err;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	ssp_link_if link_if();
	ssp_slave_end ssp_slave_end_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_mode(sleep_mode), .int_req(int_req),
		.wake_req(wake_req), .link(link_if));
	ssp_master_end ssp_master_end_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel_m), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_m), .pready(pready_m), .pslverr(pslverr_m),
		.link(link_if));
	ssp_link_sva ssp_link_sva_inst (.pclk(pclk), .presetn(presetn),
		.ck(link_if.ck), .dev_dt_o(link_if.dev_dt_o),
		.dev_dt_oe_n(link_if.dev_dt_oe_n), .mst_dt_o(link_if.mst_dt_o),
		.mst_dt_oe_n(link_if.mst_dt_oe_n), .dt(link_if.dt));
	always #12.5 pclk = ~pclk;
	// Prints the verdict and ends the run.
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end
	// One APB transfer to the master (m=1) or slave; read data in r.
	task automatic apb(input bit m, input bit w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= !m;
		psel_m <= m;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while ((m ? pready_m : pready) !== 1'b1) @(posedge pclk);
		r = m ? prdata_m : prdata;
		err = m ? pslverr_m : pslverr;
		psel <= 1'b0;
		psel_m <= 1'b0;
		penable <= 1'b0;
	endtask
	// Runs one master word and returns what the master received.
	task automatic xfer(input logic [31:0] cmd);
		apb(1, 1, OFS_M_CMD, cmd);
		do apb(1, 0, OFS_M_STAT, 0); while (r[ST_DONE] !== 1'b1);
		apb(1, 0, OFS_M_RXD, 0);
	endtask
	// Main sequence: transmit, then receive.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 0, OFS_TX_CTRL, 0);
		`CHK(r, 32'h00000002)
		apb(0, 0, 8'h20, 0);
		`CHK({err, r}, 33'h100000000)
		apb(0, 1, OFS_RCV_CTRL, 32'h00000080);
		apb(0, 1, OFS_TX_CTRL, 32'h00000030);
		apb(0, 1, OFS_INT_EN, 32'h00000001);
		apb(0, 1, OFS_INT_CTRL, 32'h000000C0);
		apb(0, 1, OFS_TX_HOLD, 32'h000000A5);
		apb(0, 1, OFS_TX_HOLD, 32'h0000003C);
		sleep_mode <= 1'b1;
		apb(0, 0, OFS_INT_FLAG, 0);
		`CHK({wake_req, int_req, r}, 34'h0)
		xfer(32'h0);
		`CHK(r, 32'h000000A5)
		apb(0, 0, OFS_INT_FLAG, 0);
		`CHK({wake_req, int_req, r}, 34'h300000001)
		xfer(32'h0);
		`CHK(r, 32'h0000003C)
		apb(0, 0, OFS_TX_CTRL, 0);
		`CHK(r, 32'h00000032)
		apb(0, 1, OFS_TX_CTRL, 32'h00000071);
		apb(0, 1, OFS_TX_HOLD, 32'h0000005A);
		xfer(32'h00000200);
		`CHK(r, 32'h0000015A)
		apb(0, 1, OFS_TX_CTRL, 32'h00000010);
		apb(0, 1, OFS_INT_EN, 32'h00000002);
		apb(0, 1, OFS_RCV_CTRL, 32'h000000A0);
		xfer(32'h000004C3);
		apb(0, 0, OFS_INT_FLAG, 0);
		`CHK(r[1], 1'b0)
		apb(0, 1, OFS_RCV_CTRL, 32'h00000090);
		// The last bit is low, so a sample after the master lets go fails.
		xfer(32'h00000443);
		apb(0, 0, OFS_INT_FLAG, 0);
		`CHK({wake_req, int_req, r[1]}, 3'b111)
		apb(0, 1, OFS_RCV_CTRL, 32'h000000D0);
		xfer(32'h000007A5);
		apb(0, 0, OFS_RCV_CTRL, 0);
		`CHK(r[1], 1'b1)
		apb(0, 0, OFS_RX_HOLD, 0);
		`CHK(r, 32'h00000043)
		apb(0, 1, OFS_RCV_CTRL, 32'h00000080);
		apb(0, 0, OFS_RCV_CTRL, 0);
		`CHK(r, 32'h00000080)
		apb(0, 1, OFS_RCV_CTRL, 32'h000000D0);
		xfer(32'h000007A5);
		apb(0, 0, OFS_RCV_CTRL, 0);
		`CHK(r, 32'h000000D1)
		apb(0, 0, OFS_RX_HOLD, 0);
		`CHK(r, 32'h000000A5)
		report_and_stop();
	end
endmodule
`default_nettype wire
